/* rtl/ocp_cfg_pkg.sv */
// package for the channel current-limit and inrush configuration register
// assumes a 100 MHz system clock and a decoded register access port
package ocp_cfg_pkg;

	// register map
	localparam logic [7:0] CH1_CURRENT_LIMIT_CONFIG_OFS = 8'h0F;
	localparam logic [15:0] CH1_CURRENT_LIMIT_CONFIG_RST = 16'h0088;

	// field positions
	localparam int PULSE_PEAK_LSB = 14;
	localparam int CHARGING_MODE_LSB = 12;
	localparam int WIRE_HEAT_EN_BIT = 11;
	localparam int PERIOD_LENGTH_LSB = 8;
	localparam int LIMIT_OR_RAMP_LSB = 4;
	localparam int STEADY_THRESHOLD_LSB = 0;

	// charging modes
	localparam logic [1:0] MODE_NONE = 2'h0;
	localparam logic [1:0] MODE_RAMP = 2'h1;
	localparam logic [1:0] MODE_REGULATE = 2'h2;
	localparam logic [1:0] MODE_PULSE = 2'h3;

	// highest supported threshold code
	localparam logic [3:0] THRESHOLD_CODE_MAX = 4'hC;
	// regulation limit divisor
	localparam logic [9:0] REGULATE_DIVISOR = 10'h005;

	// timing
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned MS_PER_S = 1000;
	localparam int unsigned CYCLES_PER_MS = CLK_HZ / MS_PER_S;

	typedef struct packed {
		logic [1:0] pulse_peak_threshold;
		logic [1:0] load_charging_mode;
		logic wire_heating_protect_enable;
		logic [2:0] startup_period_length;
		logic [3:0] startup_limit_or_ramp;
		logic [3:0] steady_overcurrent_threshold;
	} limit_cfg_t;

endpackage : ocp_cfg_pkg

/* rtl/channel_overcurrent_inrush_config.sv */
// channel current-limit and inrush configuration register with inrush sequencing
// assumes inputs synchronous to i_clk_sys and a decoded serial register port
// What this block does
// - two-bit charging mode picks none, voltage ramp, current regulation or pulse method
// - during inrush with a charging mode, no pulse-width operation and no heat accumulation
// - pulse mode: two-bit field gives peak 47.5, 55, 62.5 or 70 A
// - heat protection enable may precede turn-on; accumulation waits for charging end
// - three-bit period field gives 0,2,4,6,10,20,50,100 ms of inrush
// - mode 0: inrush field is inrush threshold, same mapping as steady field
// - mode 2: regulation limit is steady mapping of inrush code divided by five
// - mode 1: inrush field is ramp rate, only nine codes supported
// - mode 3: inrush field passes on as pulse charging parameters
// - steady threshold codes 0 to C map 10 A to 70 A, rest unsupported
// - register resets to 0088h, both threshold fields at code 8
// - overcurrent trip latches fault, cleared by status read once overcurrent is gone; off with heat protection
`timescale 1ns/100ps
module channel_overcurrent_inrush_config #(
	parameter int unsigned P_CYCLES_PER_MS = ocp_cfg_pkg::CYCLES_PER_MS
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	// register port
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	output logic [15:0] o_reg_rdata,
	output logic o_reg_rvalid,
	// channel control and analog status
	input wire logic i_channel_on,
	input wire logic i_pwm_enable_req,
	input wire logic i_oc_trip,
	input wire logic i_oc_present,
	input wire logic i_status_read,
	// protection settings
	output logic o_inrush_active,
	output logic [1:0] o_charging_mode,
	output logic [9:0] o_ocp_threshold,
	output logic o_threshold_supported,
	output logic [9:0] o_regulation_limit,
	output logic [7:0] o_ramp_rate,
	output logic o_ramp_supported,
	output logic [3:0] o_pulse_params,
	output logic o_pwm_active,
	output logic o_wire_heat_accum,
	output logic o_oc_fault
);

	// refuse a rate whose 100 ms load would overflow the 32-bit timer
	if (P_CYCLES_PER_MS < 1 || P_CYCLES_PER_MS > 32'h0262_5A00) begin : cycles_range_g
		$error("P_CYCLES_PER_MS out of range");
	end

	typedef enum logic [1:0] {ST_IDLE, ST_INRUSH, ST_STEADY} inrush_state_t;

	// threshold in units of 100 mA
	function automatic logic [9:0] threshold_of(input logic [3:0] code);
		case (code)
			4'h0: threshold_of = 10'h064;
			4'h1: threshold_of = 10'h07D;
			4'h2: threshold_of = 10'h096;
			4'h3: threshold_of = 10'h0AF;
			4'h4: threshold_of = 10'h0C8;
			4'h5: threshold_of = 10'h0E1;
			4'h6: threshold_of = 10'h0FA;
			4'h7: threshold_of = 10'h145;
			4'h8: threshold_of = 10'h190;
			4'h9: threshold_of = 10'h1DB;
			4'hA: threshold_of = 10'h226;
			4'hB: threshold_of = 10'h271;
			4'hC: threshold_of = 10'h2BC;
			default: threshold_of = 10'h000;
		endcase
	endfunction : threshold_of

	// pulse peak in units of 100 mA
	function automatic logic [9:0] peak_of(input logic [1:0] code);
		case (code)
			2'h0: peak_of = 10'h1DB;
			2'h1: peak_of = 10'h226;
			2'h2: peak_of = 10'h271;
			default: peak_of = 10'h2BC;
		endcase
	endfunction : peak_of

	// ramp rate in units of 10 mV/ms, zero when unsupported
	function automatic logic [7:0] ramp_of(input logic [3:0] code);
		case (code)
			4'h3: ramp_of = 8'hDE;
			4'h5: ramp_of = 8'h64;
			4'h6: ramp_of = 8'h85;
			4'h7: ramp_of = 8'hA6;
			4'h9: ramp_of = 8'h43;
			4'hA: ramp_of = 8'h59;
			4'hB: ramp_of = 8'h6E;
			4'hC: ramp_of = 8'h21;
			4'hD: ramp_of = 8'h32;
			default: ramp_of = 8'h00;
		endcase
	endfunction : ramp_of

	function automatic logic [6:0] period_ms_of(input logic [2:0] code);
		case (code)
			3'h0: period_ms_of = 7'h00;
			3'h1: period_ms_of = 7'h02;
			3'h2: period_ms_of = 7'h04;
			3'h3: period_ms_of = 7'h06;
			3'h4: period_ms_of = 7'h0A;
			3'h5: period_ms_of = 7'h14;
			3'h6: period_ms_of = 7'h32;
			default: period_ms_of = 7'h64;
		endcase
	endfunction : period_ms_of

	ocp_cfg_pkg::limit_cfg_t cfg_reg;
	inrush_state_t state_reg;
	logic on_d_reg;
	logic [31:0] count_reg;
	logic turn_on;
	logic cfg_hit;
	logic [31:0] count_load;
	logic inrush;
	logic [9:0] threshold_next;

	assign turn_on = i_channel_on && !on_d_reg;
	assign cfg_hit = i_reg_addr == ocp_cfg_pkg::CH1_CURRENT_LIMIT_CONFIG_OFS;
	assign count_load = 32'(32'(period_ms_of(cfg_reg.startup_period_length)) * P_CYCLES_PER_MS
		- 32'h0000_0001);
	assign inrush = state_reg == ST_INRUSH;

	// configuration register
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			cfg_reg <= ocp_cfg_pkg::CH1_CURRENT_LIMIT_CONFIG_RST;
		end else if (i_reg_wr && cfg_hit) begin
			cfg_reg <= i_reg_wdata;
		end
	end

	// read port, unmapped addresses read zero
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_reg_rdata <= 16'h0000;
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rvalid <= i_reg_rd;
			if (i_reg_rd) begin
				o_reg_rdata <= cfg_hit ? cfg_reg : 16'h0000;
			end
		end
	end

	// inrush sequencing
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			state_reg <= ST_IDLE;
			on_d_reg <= 1'b0;
			count_reg <= 32'h0000_0000;
		end else begin
			on_d_reg <= i_channel_on;
			case (state_reg)
				ST_IDLE: begin
					if (turn_on) begin
						count_reg <= count_load;
						state_reg <= cfg_reg.startup_period_length == 3'h0 ? ST_STEADY : ST_INRUSH;
					end
				end
				ST_INRUSH: begin
					if (!i_channel_on) begin
						state_reg <= ST_IDLE;
					end else if (count_reg == 32'h0000_0000) begin
						state_reg <= ST_STEADY;
					end else begin
						count_reg <= count_reg - 32'h0000_0001;
					end
				end
				ST_STEADY: begin
					if (!i_channel_on) begin
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// active overcurrent threshold
	always_comb begin
		threshold_next = threshold_of(cfg_reg.steady_overcurrent_threshold);
		case (cfg_reg.load_charging_mode)
			ocp_cfg_pkg::MODE_NONE: begin
				if (inrush) begin
					threshold_next = threshold_of(cfg_reg.startup_limit_or_ramp);
				end
			end
			ocp_cfg_pkg::MODE_PULSE: begin
				if (inrush) begin
					threshold_next = peak_of(cfg_reg.pulse_peak_threshold);
				end
			end
			default: begin
			end
		endcase
	end

	// protection setting outputs
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_inrush_active <= 1'b0;
			o_charging_mode <= 2'h0;
			o_ocp_threshold <= 10'h000;
			o_threshold_supported <= 1'b0;
			o_regulation_limit <= 10'h000;
			o_ramp_rate <= 8'h00;
			o_ramp_supported <= 1'b0;
			o_pulse_params <= 4'h0;
		end else begin
			o_inrush_active <= inrush;
			o_charging_mode <= cfg_reg.load_charging_mode;
			o_ocp_threshold <= threshold_next;
			o_threshold_supported <= threshold_next != 10'h000;
			o_regulation_limit <= cfg_reg.load_charging_mode == ocp_cfg_pkg::MODE_REGULATE ?
				10'(threshold_of(cfg_reg.startup_limit_or_ramp) / ocp_cfg_pkg::REGULATE_DIVISOR)
				: 10'h000;
			o_ramp_rate <= cfg_reg.load_charging_mode == ocp_cfg_pkg::MODE_RAMP ?
				ramp_of(cfg_reg.startup_limit_or_ramp) : 8'h00;
			o_ramp_supported <= ramp_of(cfg_reg.startup_limit_or_ramp) != 8'h00;
			o_pulse_params <= cfg_reg.load_charging_mode == ocp_cfg_pkg::MODE_PULSE ?
				cfg_reg.startup_limit_or_ramp : 4'h0;
		end
	end

	// pulse-width gating and heat accumulation
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_pwm_active <= 1'b0;
			o_wire_heat_accum <= 1'b0;
		end else begin
			o_pwm_active <= i_pwm_enable_req && i_channel_on
				&& cfg_reg.load_charging_mode == ocp_cfg_pkg::MODE_NONE;
			o_wire_heat_accum <= cfg_reg.wire_heating_protect_enable && i_channel_on
				&& (cfg_reg.load_charging_mode == ocp_cfg_pkg::MODE_NONE
				|| state_reg == ST_STEADY);
		end
	end

	// overcurrent fault flag, set wins over clear
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_oc_fault <= 1'b0;
		end else if (i_oc_trip && !cfg_reg.wire_heating_protect_enable) begin
			o_oc_fault <= 1'b1;
		end else if (i_status_read && !i_oc_present) begin
			o_oc_fault <= 1'b0;
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);

	write_update_a: assert property (i_reg_wr && cfg_hit |=> cfg_reg == $past(i_reg_wdata))
		else $error("config write not stored");
	inrush_suppress_a: assert property (inrush && cfg_reg.load_charging_mode != 2'h0
		|=> !o_pwm_active && !o_wire_heat_accum)
		else $error("pwm or heat active during charging");
	pulse_peak_a: assert property (inrush && cfg_reg.load_charging_mode == 2'h3
		&& cfg_reg.pulse_peak_threshold == 2'h0 |=> o_ocp_threshold == 10'h1DB)
		else $error("pulse peak wrong");
	heat_after_a: assert property (cfg_reg.wire_heating_protect_enable && i_channel_on
		&& state_reg == ST_STEADY |=> o_wire_heat_accum)
		else $error("heat accumulation missing");
	timer_load_a: assert property (state_reg == ST_IDLE && turn_on
		&& cfg_reg.startup_period_length == 3'h1
		|=> inrush && count_reg == 32'(2 * P_CYCLES_PER_MS - 1))
		else $error("inrush timer load wrong");
	inrush_thr_a: assert property (inrush && cfg_reg.load_charging_mode == 2'h0
		&& cfg_reg.startup_limit_or_ramp == 4'h9 |=> o_ocp_threshold == 10'h1DB)
		else $error("inrush threshold wrong");
	reg_limit_a: assert property (cfg_reg.load_charging_mode == 2'h2
		&& cfg_reg.startup_limit_or_ramp == 4'hC |=> o_regulation_limit == 10'h08C)
		else $error("regulation limit wrong");
	ramp_rate_a: assert property (cfg_reg.load_charging_mode == 2'h1
		&& cfg_reg.startup_limit_or_ramp == 4'h3 |=> o_ramp_rate == 8'hDE)
		else $error("ramp rate wrong");
	pulse_param_a: assert property (cfg_reg.load_charging_mode == 2'h3
		|=> o_pulse_params == $past(cfg_reg.startup_limit_or_ramp))
		else $error("pulse parameters wrong");
	steady_thr_a: assert property (state_reg == ST_STEADY
		&& cfg_reg.steady_overcurrent_threshold == 4'h2 |=> o_ocp_threshold == 10'h096)
		else $error("steady threshold wrong");
	pwm_refuse_a: assert property (cfg_reg.load_charging_mode != 2'h0 |=> !o_pwm_active)
		else $error("pwm not refused");
	fault_set_a: assert property (i_oc_trip && !cfg_reg.wire_heating_protect_enable
		|=> o_oc_fault)
		else $error("fault flag not set");
	timer_expire_a: assert property (inrush && i_channel_on && count_reg == 32'h0
		|=> state_reg == ST_STEADY ##1 o_ocp_threshold
		== threshold_of($past(cfg_reg.steady_overcurrent_threshold)))
		else $error("inrush did not end");

	inrush_end_c: cover property (inrush ##1 state_reg == ST_STEADY);
	pulse_mode_c: cover property (inrush && cfg_reg.load_charging_mode == 2'h3);
	fault_clear_c: cover property (o_oc_fault ##1 !o_oc_fault);
	cfg_write_c: cover property (i_reg_wr && cfg_hit);

endmodule : channel_overcurrent_inrush_config

/* sim/testbench.sv */
// self-checking bench for the channel current-limit configuration register
// assumes rtl/ocp_cfg_pkg.sv and the design module compiled first
`timescale 1ns/100ps
module testbench;
	localparam int CPM = 2;
	logic clk, rst_n, wr, rd, on, pwm, trip, ocp, sread;
	logic [7:0] addr;
	logic [15:0] wdata, rdata, d;
	logic rvalid, inr, sup, ramp_ok, pwm_act, heat, fault;
	logic [1:0] mode;
	logic [9:0] thr, reg_lim;
	logic [7:0] ramp;
	logic [3:0] pp;
	int err_total = 0;
	int total_checks = 0;
	// thresholds in 100 mA, ramps in 10 mV/ms, periods in ms
	logic [9:0] thr_map [16] = '{10'h064, 10'h07D, 10'h096, 10'h0AF, 10'h0C8, 10'h0E1,
		10'h0FA, 10'h145, 10'h190, 10'h1DB, 10'h226, 10'h271, 10'h2BC, 10'h000, 10'h000, 10'h000};
	logic [7:0] ramp_map [16] = '{8'h00, 8'h00, 8'h00, 8'hDE, 8'h00, 8'h64, 8'h85, 8'hA6,
		8'h00, 8'h43, 8'h59, 8'h6E, 8'h21, 8'h32, 8'h00, 8'h00};
	logic [7:0] per_ms [8] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h0A, 8'h14, 8'h32, 8'h64};
	logic [9:0] peak_map [4] = '{10'h1DB, 10'h226, 10'h271, 10'h2BC};

	channel_overcurrent_inrush_config #(.P_CYCLES_PER_MS(CPM)) DUT (.i_clk_sys(clk),
		.i_resetn(rst_n), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
		.i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
		.i_channel_on(on), .i_pwm_enable_req(pwm), .i_oc_trip(trip), .i_oc_present(ocp),
		.i_status_read(sread), .o_inrush_active(inr), .o_charging_mode(mode),
		.o_ocp_threshold(thr), .o_threshold_supported(sup), .o_regulation_limit(reg_lim),
		.o_ramp_rate(ramp), .o_ramp_supported(ramp_ok), .o_pulse_params(pp),
		.o_pwm_active(pwm_act), .o_wire_heat_accum(heat), .o_oc_fault(fault));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_bit(input logic got, input logic exp);
		chk({15'h0000, got}, {15'h0000, exp});
	endtask : chk_bit

	function automatic logic [15:0] cfg(input logic [1:0] pk, input logic [1:0] md,
		input logic ht, input logic [2:0] pr, input logic [3:0] lm, input logic [3:0] th);
		return {pk, md, ht, pr, lm, th};
	endfunction : cfg

	// all tasks start and end one step after a rising edge
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
		addr = a;
		wdata = v;
		wr = 1'b1;
		step(1);
		wr = 1'b0;
		step(2);
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
		addr = a;
		rd = 1'b1;
		step(1);
		rd = 1'b0;
		for (int k = 0; k < 3 && rvalid !== 1'b1; k++) step(1);
		if (rvalid !== 1'b1) begin
			err_total++;
			print_verdict();
		end
		v = rdata;
	endtask : rd_reg

	// turn on, count inrush cycles, check inrush and steady outputs
	task automatic run_inrush(input logic [2:0] pr, input logic [9:0] ti, input logic [9:0] ts,
		input logic [1:0] fin, input logic [1:0] fst);
		int n;
		logic [1:0] seen;
		n = 0;
		seen = 2'h0;
		on = 1'b1;
		repeat (220) begin
			step(1);
			if (inr === 1'b1) begin
				if (n == 0) chk({6'h00, thr}, {6'h00, ti});
				n++;
				seen = seen | {heat, pwm_act};
			end
		end
		chk(16'(n), 16'(int'(per_ms[pr]) * CPM));
		chk({14'h0000, seen}, {14'h0000, fin});
		chk({6'h00, thr}, {6'h00, ts});
		chk({14'h0000, heat, pwm_act}, {14'h0000, fst});
		on = 1'b0;
		step(3);
	endtask : run_inrush

	task automatic pulse(ref logic s);
		s = 1'b1;
		step(1);
		s = 1'b0;
		step(2);
	endtask : pulse

	initial begin
		#500000;
		err_total++;
		print_verdict();
	end

	initial begin
		{rst_n, wr, rd, on, pwm, trip, ocp, sread} = 8'h00;
		addr = 8'h00;
		wdata = 16'h0000;
		step(6);
		rst_n = 1'b1;
		step(2);
		rd_reg(8'h0F, d);
		chk(d, 16'h0088);
		chk({6'h00, thr}, 16'h0190);
		$display("test reset done");
		wr_reg(8'h0F, 16'hFFFF);
		wr_reg(8'h10, 16'h0000);
		rd_reg(8'h0F, d);
		chk(d, 16'hFFFF);
		rd_reg(8'h10, d);
		chk(d, 16'h0000);
		$display("test access done");
		for (int c = 0; c < 16; c++) begin
			wr_reg(8'h0F, cfg(2'h0, 2'h0, 1'b0, 3'h0, 4'h8, 4'(c)));
			chk({6'h00, thr}, {6'h00, thr_map[c]});
			chk_bit(sup, c < 13);
		end
		$display("test steady done");
		for (int m = 0; m < 4; m++) for (int c = 0; c < 16; c++) begin
			wr_reg(8'h0F, cfg(2'h0, 2'(m), 1'b0, 3'h0, 4'(c), 4'h8));
			chk({14'h0000, mode}, 16'(m));
			chk({8'h00, ramp}, {8'h00, m == 1 ? ramp_map[c] : 8'h00});
			chk_bit(ramp_ok, ramp_map[c] != 8'h00);
			chk({6'h00, reg_lim}, {6'h00, m == 2 ? thr_map[c] / 10'h005 : 10'h000});
			chk({12'h000, pp}, {12'h000, m == 3 ? 4'(c) : 4'h0});
		end
		$display("test modes done");
		for (int p = 0; p < 8; p++) begin
			wr_reg(8'h0F, cfg(2'h0, 2'h0, 1'b0, 3'(p), 4'h9, 4'h2));
			run_inrush(3'(p), thr_map[9], thr_map[2], 2'h0, 2'h0);
		end
		for (int k = 0; k < 4; k++) begin
			wr_reg(8'h0F, cfg(2'(k), 2'h3, 1'b0, 3'h1, 4'h5, 4'h3));
			run_inrush(3'h1, peak_map[k], thr_map[3], 2'h0, 2'h0);
		end
		pwm = 1'b1;
		wr_reg(8'h0F, cfg(2'h0, 2'h1, 1'b1, 3'h2, 4'h3, 4'h4));
		run_inrush(3'h2, thr_map[4], thr_map[4], 2'h0, 2'h2);
		wr_reg(8'h0F, cfg(2'h0, 2'h0, 1'b0, 3'h1, 4'h4, 4'h4));
		run_inrush(3'h1, thr_map[4], thr_map[4], 2'h1, 2'h1);
		pwm = 1'b0;
		$display("test inrush done");
		pulse(trip);
		chk_bit(fault, 1'b1);
		ocp = 1'b1;
		pulse(sread);
		chk_bit(fault, 1'b1);
		ocp = 1'b0;
		pulse(sread);
		chk_bit(fault, 1'b0);
		wr_reg(8'h0F, cfg(2'h0, 2'h0, 1'b1, 3'h0, 4'h8, 4'h8));
		pulse(trip);
		chk_bit(fault, 1'b0);
		$display("test fault done");
		print_verdict();
	end
endmodule : testbench
